// ---- core/perf_count_pkg.sv ----
// Constants and types shared by the throughput counter block.
package perf_count_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SECOND_NS = 1000000000;
    localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int COUNT_W = 32;
    localparam int BEAT_W = 5;
    localparam int NUM_COUNTERS = 10;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [BEAT_W-1:0] BEAT_ZERO = 5'h00;
    localparam logic [COUNT_W-1:0] MONITOR_INTERVAL_RESET = 32'h0098_9680;
    // Slot of each counter in the counter bank
    localparam int IDX_C2H = 0;
    localparam int IDX_H2C = 1;
    localparam int IDX_TX_TOTAL = 2;
    localparam int IDX_RX_TOTAL = 3;
    localparam int IDX_TX_PAYLOAD = 4;
    localparam int IDX_RX_PAYLOAD = 5;
    localparam int IDX_PA_RD = 6;
    localparam int IDX_PA_WR = 7;
    localparam int IDX_PB_RD = 8;
    localparam int IDX_PB_WR = 9;
    localparam int FIRST_MONITOR = IDX_PA_RD;

    // Transaction kind tagged on each transaction interface beat
    typedef enum logic [1:0] {
        KIND_OTHER = 2'b00,
        KIND_MEM_WRITE = 2'b01,
        KIND_COMPLETION = 2'b10,
        KIND_MEM_READ = 2'b11
    } tlp_kind_t;
endpackage : perf_count_pkg

// ---- core/window_byte_counter.sv ----
// Byte accumulator that publishes its total and restarts on a boundary tick.
`timescale 1ns/10ps
`default_nettype none
module window_byte_counter
    import perf_count_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic add_valid_in,
    input wire logic [BEAT_W-1:0] add_bytes_in,
    input wire logic tick_in,
    output logic [COUNT_W-1:0] count_out
);
    logic [COUNT_W-1:0] acc;
    logic [COUNT_W-1:0] add_amount;
    logic [COUNT_W-1:0] next_acc;

    // Bytes of the boundary cycle belong to the closing window
    assign add_amount = add_valid_in ? COUNT_W'(add_bytes_in) : COUNT_RESET;
    assign next_acc = acc + add_amount;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            acc <= COUNT_RESET;
            count_out <= COUNT_RESET;
        end else if (tick_in) begin
            acc <= COUNT_RESET;
            count_out <= next_acc;
        end else begin
            acc <= next_acc;
        end
    end

    a_load_full_sum: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        tick_in |=> count_out == $past(acc) + $past(add_amount))
        else $error("published count differs from window total");
    a_restart_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        tick_in |=> acc == COUNT_RESET)
        else $error("accumulator did not restart at boundary");
    a_hold_between: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !tick_in |=> $stable(count_out))
        else $error("published count changed without a boundary");
endmodule : window_byte_counter
`default_nettype wire

// ---- core/throughput_counters.sv ----
// Throughput counters for the PCIe DMA path and two processor memory ports.
`timescale 1ns/10ps
`default_nettype none
module throughput_counters
    import perf_count_pkg::*;
#(
    parameter int unsigned ONE_SECOND_CYCLES = SECOND_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic tx_beat_in,
    input wire logic [BEAT_W-1:0] tx_bytes_in,
    input wire logic [BEAT_W-1:0] tx_hdr_bytes_in,
    input wire logic [1:0] tx_kind_in,
    input wire logic rx_beat_in,
    input wire logic [BEAT_W-1:0] rx_bytes_in,
    input wire logic [BEAT_W-1:0] rx_hdr_bytes_in,
    input wire logic [1:0] rx_kind_in,
    input wire logic card_to_host_engine_valid_in,
    input wire logic card_to_host_engine_ready_in,
    input wire logic [BEAT_W-1:0] card_to_host_engine_bytes_in,
    input wire logic host_to_card_engine_valid_in,
    input wire logic host_to_card_engine_ready_in,
    input wire logic [BEAT_W-1:0] host_to_card_engine_bytes_in,
    input wire logic memory_port_a_rd_beat_in,
    input wire logic [BEAT_W-1:0] memory_port_a_rd_bytes_in,
    input wire logic memory_port_a_wr_beat_in,
    input wire logic [BEAT_W-1:0] memory_port_a_wr_bytes_in,
    input wire logic memory_port_b_rd_beat_in,
    input wire logic [BEAT_W-1:0] memory_port_b_rd_bytes_in,
    input wire logic memory_port_b_wr_beat_in,
    input wire logic [BEAT_W-1:0] memory_port_b_wr_bytes_in,
    input wire logic [COUNT_W-1:0] monitor_interval_in,
    output logic [COUNT_W-1:0] card_to_host_engine_count_out,
    output logic [COUNT_W-1:0] host_to_card_engine_count_out,
    output logic [COUNT_W-1:0] tx_total_count_out,
    output logic [COUNT_W-1:0] rx_total_count_out,
    output logic [COUNT_W-1:0] tx_payload_count_out,
    output logic [COUNT_W-1:0] rx_payload_count_out,
    output logic [COUNT_W-1:0] memory_port_a_rd_count_out,
    output logic [COUNT_W-1:0] memory_port_a_wr_count_out,
    output logic [COUNT_W-1:0] memory_port_b_rd_count_out,
    output logic [COUNT_W-1:0] memory_port_b_wr_count_out,
    output logic second_tick_out,
    output logic monitor_tick_out
);
    localparam logic [COUNT_W-1:0] SECOND_LAST = COUNT_W'(ONE_SECOND_CYCLES - 1);
    // Monitor starts on a one second interval, so a shortened second shortens it too
    localparam logic [COUNT_W-1:0] MONITOR_START = COUNT_W'(ONE_SECOND_CYCLES);

    // Payload part of a beat of the given kind; header bytes are stripped
    function automatic logic [BEAT_W-1:0] payload_of(
        input logic beat,
        input logic [1:0] kind,
        input tlp_kind_t want,
        input logic [BEAT_W-1:0] bytes,
        input logic [BEAT_W-1:0] hdr
    );
        if (beat && kind == want && bytes > hdr) begin
            return BEAT_W'(bytes - hdr);
        end
        return BEAT_ZERO;
    endfunction : payload_of

    logic [COUNT_W-1:0] sec_cnt;
    logic [COUNT_W-1:0] mon_cnt;
    logic [COUNT_W-1:0] mon_interval;
    logic sec_wrap;
    logic mon_wrap;
    logic [NUM_COUNTERS-1:0] add_valid;
    logic [BEAT_W-1:0] add_bytes [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] tick;
    logic [COUNT_W-1:0] counts [NUM_COUNTERS];
    logic [BEAT_W-1:0] tx_payload;
    logic [BEAT_W-1:0] rx_payload;

    // Boundary detect; an interval of zero behaves as one cycle
    assign sec_wrap = sec_cnt >= SECOND_LAST;
    assign mon_wrap = (COUNT_W + 1)'(mon_cnt) + 1'b1 >= (COUNT_W + 1)'(mon_interval);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sec_cnt <= COUNT_RESET;
            second_tick_out <= 1'b0;
        end else begin
            sec_cnt <= sec_wrap ? COUNT_RESET : sec_cnt + 1'b1;
            second_tick_out <= sec_wrap;
        end
    end

    // interval taken from configuration at each boundary
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mon_cnt <= COUNT_RESET;
            mon_interval <= MONITOR_START;
            monitor_tick_out <= 1'b0;
        end else begin
            mon_cnt <= mon_wrap ? COUNT_RESET : mon_cnt + 1'b1;
            monitor_tick_out <= mon_wrap;
            if (mon_wrap) begin
                mon_interval <= monitor_interval_in;
            end
        end
    end

    assign tx_payload = payload_of(tx_beat_in, tx_kind_in, KIND_MEM_WRITE, tx_bytes_in,
        tx_hdr_bytes_in);
    assign rx_payload = payload_of(rx_beat_in, rx_kind_in, KIND_COMPLETION, rx_bytes_in,
        rx_hdr_bytes_in);

    // engine payload counted on accepted stream beats
    assign add_valid[IDX_C2H] = card_to_host_engine_valid_in && card_to_host_engine_ready_in;
    assign add_bytes[IDX_C2H] = card_to_host_engine_bytes_in;
    assign add_valid[IDX_H2C] = host_to_card_engine_valid_in && host_to_card_engine_ready_in;
    assign add_bytes[IDX_H2C] = host_to_card_engine_bytes_in;
    assign add_valid[IDX_TX_TOTAL] = tx_beat_in;
    assign add_bytes[IDX_TX_TOTAL] = tx_bytes_in;
    assign add_valid[IDX_RX_TOTAL] = rx_beat_in;
    assign add_bytes[IDX_RX_TOTAL] = rx_bytes_in;
    assign add_valid[IDX_TX_PAYLOAD] = tx_payload != BEAT_ZERO;
    assign add_bytes[IDX_TX_PAYLOAD] = tx_payload;
    assign add_valid[IDX_RX_PAYLOAD] = rx_payload != BEAT_ZERO;
    assign add_bytes[IDX_RX_PAYLOAD] = rx_payload;
    // read and write bytes per memory port
    assign add_valid[IDX_PA_RD] = memory_port_a_rd_beat_in;
    assign add_bytes[IDX_PA_RD] = memory_port_a_rd_bytes_in;
    assign add_valid[IDX_PA_WR] = memory_port_a_wr_beat_in;
    assign add_bytes[IDX_PA_WR] = memory_port_a_wr_bytes_in;
    assign add_valid[IDX_PB_RD] = memory_port_b_rd_beat_in;
    assign add_bytes[IDX_PB_RD] = memory_port_b_rd_bytes_in;
    assign add_valid[IDX_PB_WR] = memory_port_b_wr_beat_in;
    assign add_bytes[IDX_PB_WR] = memory_port_b_wr_bytes_in;

    // PCIe and DMA counters follow the second, monitor counters their own interval
    genvar i;
    generate
        for (i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
            assign tick[i] = (i >= FIRST_MONITOR) ? mon_wrap : sec_wrap;
            window_byte_counter u_cnt (
                .clk_sys_in(clk_sys_in),
                .rst_in(rst_in),
                .add_valid_in(add_valid[i]),
                .add_bytes_in(add_bytes[i]),
                .tick_in(tick[i]),
                .count_out(counts[i])
            );
        end
    endgenerate

    // Published counts, already registered inside each counter
    assign card_to_host_engine_count_out = counts[IDX_C2H];
    assign host_to_card_engine_count_out = counts[IDX_H2C];
    assign tx_total_count_out = counts[IDX_TX_TOTAL];
    assign rx_total_count_out = counts[IDX_RX_TOTAL];
    assign tx_payload_count_out = counts[IDX_TX_PAYLOAD];
    assign rx_payload_count_out = counts[IDX_RX_PAYLOAD];
    assign memory_port_a_rd_count_out = counts[IDX_PA_RD];
    assign memory_port_a_wr_count_out = counts[IDX_PA_WR];
    assign memory_port_b_rd_count_out = counts[IDX_PB_RD];
    assign memory_port_b_wr_count_out = counts[IDX_PB_WR];

    a_second_tick_due: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        sec_cnt == SECOND_LAST |=> second_tick_out && sec_cnt == COUNT_RESET)
        else $error("second boundary missed");
    a_second_tick_only: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        second_tick_out |-> $past(sec_cnt) == SECOND_LAST)
        else $error("second boundary at wrong count");
    a_tx_payload_kind: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (tx_kind_in != KIND_MEM_WRITE || !tx_beat_in) |-> !add_valid[IDX_TX_PAYLOAD])
        else $error("non write bytes in transmit payload");
    a_rx_payload_kind: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        rx_beat_in && rx_kind_in == KIND_COMPLETION && rx_bytes_in > rx_hdr_bytes_in
        |-> rx_payload == BEAT_W'(rx_bytes_in - rx_hdr_bytes_in))
        else $error("completion payload miscounted");
    a_tx_total_all: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        tx_beat_in && sec_wrap |=> tx_total_count_out >= COUNT_W'($past(tx_bytes_in)))
        else $error("transmit total lost boundary bytes");
    a_rx_total_all: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        rx_beat_in && sec_wrap |=> rx_total_count_out >= COUNT_W'($past(rx_bytes_in)))
        else $error("receive total lost boundary bytes");
    a_engine_accept: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !(card_to_host_engine_valid_in && card_to_host_engine_ready_in) && !sec_wrap
        |=> $stable(g_cnt[IDX_C2H].u_cnt.acc))
        else $error("engine count took a beat without handshake");
    a_monitor_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !mon_wrap |=> $stable(memory_port_a_rd_count_out) && !monitor_tick_out)
        else $error("monitor count changed mid interval");
    a_monitor_config: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        mon_wrap |=> mon_interval == $past(monitor_interval_in) && mon_cnt == COUNT_RESET)
        else $error("monitor interval not taken at boundary");

    c_second_tick: cover property (@(posedge clk_sys_in) disable iff (rst_in) second_tick_out);
    c_monitor_tick: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        monitor_tick_out ##[1:20] monitor_tick_out);
    c_boundary_beat: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        sec_wrap && tx_payload != BEAT_ZERO);
endmodule : throughput_counters
`default_nettype wire

// ---- verification/test_pcie_throughput_counters.sv ----
// Self-checking bench for the throughput counter block.
`timescale 1ns/10ps
`default_nettype none
module test_pcie_throughput_counters;
    import perf_count_pkg::*;
    localparam int N = 16;
    typedef struct {logic [4:0] b, h; logic [1:0] k; logic v, r; logic [4:0] tp, rp;} row_t;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic tx_beat_in, rx_beat_in, card_to_host_engine_valid_in, card_to_host_engine_ready_in;
    logic host_to_card_engine_valid_in, host_to_card_engine_ready_in;
    logic memory_port_a_rd_beat_in, memory_port_a_wr_beat_in;
    logic memory_port_b_rd_beat_in, memory_port_b_wr_beat_in;
    logic [4:0] tx_bytes_in, tx_hdr_bytes_in, rx_bytes_in, rx_hdr_bytes_in;
    logic [4:0] card_to_host_engine_bytes_in, host_to_card_engine_bytes_in;
    logic [4:0] memory_port_a_rd_bytes_in, memory_port_a_wr_bytes_in;
    logic [4:0] memory_port_b_rd_bytes_in, memory_port_b_wr_bytes_in;
    logic [1:0] tx_kind_in, rx_kind_in;
    logic [31:0] monitor_interval_in = 32'h0000_0010;
    logic [31:0] card_to_host_engine_count_out, host_to_card_engine_count_out;
    logic [31:0] tx_total_count_out, rx_total_count_out, tx_payload_count_out;
    logic [31:0] rx_payload_count_out, memory_port_a_rd_count_out, memory_port_a_wr_count_out;
    logic [31:0] memory_port_b_rd_count_out, memory_port_b_wr_count_out;
    logic second_tick_out, monitor_tick_out;
    int err_total = 0;
    int checks_done = 0;
    // Rows: bytes, header, kind, valid, ready, then payload per beat on tx and rx
    row_t idle = '{5'h00, 5'h00, 2'h0, 1'b0, 1'b0, 5'h00, 5'h00};
    row_t rows [6] = '{
        '{5'h1F, 5'h0C, 2'h1, 1'b1, 1'b1, 5'h13, 5'h00},
        '{5'h14, 5'h14, 2'h2, 1'b1, 1'b0, 5'h00, 5'h00},
        '{5'h18, 5'h04, 2'h2, 1'b0, 1'b1, 5'h00, 5'h14},
        '{5'h10, 5'h0C, 2'h3, 1'b1, 1'b1, 5'h00, 5'h00},
        '{5'h08, 5'h00, 2'h0, 1'b1, 1'b1, 5'h00, 5'h00},
        '{5'h03, 5'h05, 2'h1, 1'b0, 1'b0, 5'h00, 5'h00}};

    throughput_counters #(.ONE_SECOND_CYCLES(N)) uut (.clk_sys_in, .rst_in,
        .tx_beat_in, .tx_bytes_in, .tx_hdr_bytes_in, .tx_kind_in,
        .rx_beat_in, .rx_bytes_in, .rx_hdr_bytes_in, .rx_kind_in,
        .card_to_host_engine_valid_in, .card_to_host_engine_ready_in,
        .card_to_host_engine_bytes_in, .host_to_card_engine_valid_in,
        .host_to_card_engine_ready_in, .host_to_card_engine_bytes_in,
        .memory_port_a_rd_beat_in, .memory_port_a_rd_bytes_in, .memory_port_a_wr_beat_in,
        .memory_port_a_wr_bytes_in, .memory_port_b_rd_beat_in, .memory_port_b_rd_bytes_in,
        .memory_port_b_wr_beat_in, .memory_port_b_wr_bytes_in, .monitor_interval_in,
        .card_to_host_engine_count_out, .host_to_card_engine_count_out,
        .tx_total_count_out, .rx_total_count_out, .tx_payload_count_out,
        .rx_payload_count_out, .memory_port_a_rd_count_out, .memory_port_a_wr_count_out,
        .memory_port_b_rd_count_out, .memory_port_b_wr_count_out,
        .second_tick_out, .monitor_tick_out);

    // 10 MHz system clock
    always #50 clk_sys_in = ~clk_sys_in;

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask : chk

    // Same beat every cycle of a window, so totals are sixteen times one beat
    task apply(input row_t x);
        {tx_beat_in, rx_beat_in} = 2'b11;
        {tx_bytes_in, tx_hdr_bytes_in, tx_kind_in} = {x.b, x.h, x.k};
        {rx_bytes_in, rx_hdr_bytes_in, rx_kind_in} = {x.b, x.h, x.k};
        {card_to_host_engine_valid_in, card_to_host_engine_ready_in} = {x.v, x.r};
        {host_to_card_engine_valid_in, host_to_card_engine_ready_in} = {1'b1, x.r};
        card_to_host_engine_bytes_in = x.b;
        host_to_card_engine_bytes_in = x.h;
        {memory_port_a_rd_beat_in, memory_port_a_wr_beat_in} = {1'b1, x.v};
        {memory_port_b_rd_beat_in, memory_port_b_wr_beat_in} = {x.r, 1'b1};
        {memory_port_a_rd_bytes_in, memory_port_a_wr_bytes_in} = {x.b, x.h};
        {memory_port_b_rd_bytes_in, memory_port_b_wr_bytes_in} = {x.h, x.b};
    endtask : apply

    // Monitor interval equals the second here, so its totals land with the PCIe ones
    task check_row(input row_t x, input logic tk);
        chk("c2h count", (x.v && x.r) ? 32'(N * x.b) : 32'h0, card_to_host_engine_count_out);
        chk("h2c count", x.r ? 32'(N * x.h) : 32'h0, host_to_card_engine_count_out);
        chk("tx total", 32'(N * x.b), tx_total_count_out);
        chk("rx total", 32'(N * x.b), rx_total_count_out);
        chk("tx payload", 32'(N * x.tp), tx_payload_count_out);
        chk("rx payload", 32'(N * x.rp), rx_payload_count_out);
        chk("port a read", 32'(N * x.b), memory_port_a_rd_count_out);
        chk("port a write", x.v ? 32'(N * x.h) : 32'h0, memory_port_a_wr_count_out);
        chk("port b read", x.r ? 32'(N * x.h) : 32'h0, memory_port_b_rd_count_out);
        chk("port b write", 32'(N * x.b), memory_port_b_wr_count_out);
        chk("monitor tick", 32'(tk), 32'(monitor_tick_out));
    endtask : check_row

    // Bounded wait for the boundary tick, returning the cycles waited
    task wait_tick(output int n);
        n = 0;
        do begin
            @(negedge clk_sys_in);
            n++;
        end while (second_tick_out !== 1'b1 && n < 40);
    endtask : wait_tick

    task give_verdict;
        $display("checks_done %0d err_total %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        int n;
        apply(idle);
        repeat (16) @(negedge clk_sys_in);
        rst_in = 1'b0;
        wait_tick(n);
        chk("first period", 32'(N), 32'(n));
        check_row(idle, 1'b1);
        // Windows run back to back, so the boundary cycles carry beats too
        foreach (rows[i]) begin
            apply(rows[i]);
            wait_tick(n);
            chk("second period", 32'(N), 32'(n));
            check_row(rows[i], 1'b1);
        end
        // Reset in mid-window clears every published total
        apply(rows[0]);
        repeat (5) @(negedge clk_sys_in);
        rst_in = 1'b1;
        apply(idle);
        repeat (2) @(negedge clk_sys_in);
        check_row(idle, 1'b0);
        chk("tick in reset", 32'h0, 32'(second_tick_out));
        rst_in = 1'b0;
        wait_tick(n);
        chk("first period after reset", 32'(N), 32'(n));
        check_row(idle, 1'b1);
        apply(rows[2]);
        wait_tick(n);
        chk("period after reset", 32'(N), 32'(n));
        check_row(rows[2], 1'b1);
        // Shorter monitor interval applies only from the next monitor boundary
        monitor_interval_in = 32'h0000_0008;
        wait_tick(n);
        chk("period before new interval", 32'(N), 32'(n));
        chk("monitor tick old interval", 32'h1, 32'(monitor_tick_out));
        n = 0;
        do begin
            @(negedge clk_sys_in);
            n++;
        end while (monitor_tick_out !== 1'b1 && n < 40);
        chk("monitor period", 32'h8, 32'(n));
        chk("port a read short", 32'(8 * rows[2].b), memory_port_a_rd_count_out);
        chk("port b read short", 32'(8 * rows[2].h), memory_port_b_rd_count_out);
        chk("second tick mid window", 32'h0, 32'(second_tick_out));
        give_verdict();
    end

    // Watchdog well beyond the dozen windows the run needs
    initial begin
        #(3000 * 100);
        err_total++;
        give_verdict();
    end
endmodule : test_pcie_throughput_counters
`default_nettype wire
